/* File: core/sdms_sequencer.sv */
// Purpose: Step/dir front end that walks a microstep angle and drives coil targets.
// Assumes: Step and direction pins are asynchronous to clk; rst is synchronous.
// Notes:   Configuration bits arrive as plain ports from the control word.

`timescale 1ns/100ps

module sdms_sequencer
    import sdms_pkg::*;
#(
    parameter int STANDSTILL_CYCLES = STANDSTILL_CYCLES_DFLT
)
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     step_pin,
    input  wire logic                     dir_pin,
    input  wire logic                     dual_edge_select,
    input  wire logic [RES_W-1:0]         microstep_resolution,
    input  wire logic                     step_interface_disable,
    output logic      [ANGLE_W-1:0]       microstep_angle,
    output logic signed [COIL_W-1:0]      coil_a_target,
    output logic signed [COIL_W-1:0]      coil_b_target,
    output logic                          standstill_flag
);

    // ==================================================================
    // Declarations
    logic                     step_s1_r;
    logic                     step_s2_r;
    logic                     step_prev_r;
    logic                     dir_s1_r;
    logic                     dir_s2_r;
    logic                     step_act;
    logic [ANGLE_W-1:0]       step_size;
    logic [ANGLE_W-1:0]       angle_r;
    logic [ANGLE_W-1:0]       angle_nxt;
    logic signed [COIL_W-1:0] sine_val;
    logic signed [COIL_W-1:0] cosine_val;
    logic signed [COIL_W-1:0] coil_a_r;
    logic signed [COIL_W-1:0] coil_b_r;
    logic [IDLE_CNT_W-1:0]    idle_cnt_r;
    logic                     standstill_r;

    localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(STANDSTILL_CYCLES - 1);

    // Power-of-two step; codes beyond full step clamp so the angle stays aligned.
    function automatic logic [ANGLE_W-1:0] res_to_step(input logic [RES_W-1:0] res);
        logic [RES_W-1:0] r;
        r = (res > RES_COARSEST) ? RES_COARSEST : res;
        res_to_step = ANGLE_W'(1) << r;
    endfunction

    // ==================================================================
    // Input synchronisers. Only the second stage feeds any logic.
    always_ff @(posedge clk) begin
        if (rst) begin
            step_s1_r <= 1'b0;
            step_s2_r <= 1'b0;
            dir_s1_r  <= 1'b0;
            dir_s2_r  <= 1'b0;
        end else begin
            step_s1_r <= step_pin;
            step_s2_r <= step_s1_r;
            dir_s1_r  <= dir_pin;
            dir_s2_r  <= dir_s1_r;
        end
    end

    // Edge history on the synchronised step level.
    always_ff @(posedge clk) begin
        if (rst) begin
            step_prev_r <= 1'b0;
        end else begin
            step_prev_r <= step_s2_r;
        end
    end

    // ==================================================================
    // Active edge detection. A disabled step interface ignores all pulses.
    always_comb begin
        if (step_interface_disable) begin
            step_act = 1'b0;
        end else if (dual_edge_select) begin
            step_act = step_s2_r ^ step_prev_r;
        end else begin
            step_act = step_s2_r & ~step_prev_r;
        end
    end

    // The pulse limit is the controller's duty; faster input simply merges edges.
    assign step_size = res_to_step(microstep_resolution);

    // ==================================================================
    // Angle counter; wraps naturally at the 10-bit boundary.
    always_comb begin
        angle_nxt = angle_r;
        if (step_act) begin
            if (dir_s2_r) begin
                angle_nxt = angle_r - step_size;
            end else begin
                angle_nxt = angle_r + step_size;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            angle_r <= ANGLE_RST;
        end else begin
            angle_r <= angle_nxt;
        end
    end

    // ==================================================================
    // Coil targets; coil A follows sine and coil B cosine of the angle.
    sdms_quad_rom u_rom (
        .angle      (angle_r),
        .sine_val   (sine_val),
        .cosine_val (cosine_val)
    );

    // Registered so the table mux does not reach the outputs; one cycle lag.
    always_ff @(posedge clk) begin
        if (rst) begin
            coil_a_r <= '0;
            coil_b_r <= '0;
        end else begin
            coil_a_r <= sine_val;
            coil_b_r <= cosine_val;
        end
    end

    // ==================================================================
    // Standstill detection: counts idle clocks, saturates at the limit.
    always_ff @(posedge clk) begin
        if (rst) begin
            idle_cnt_r   <= '0;
            standstill_r <= 1'b0;
        end else if (step_act) begin
            idle_cnt_r   <= '0;
            standstill_r <= 1'b0;
        end else if (idle_cnt_r == IDLE_LAST) begin
            standstill_r <= 1'b1;
        end else begin
            idle_cnt_r   <= idle_cnt_r + IDLE_CNT_W'(1);
        end
    end

    assign microstep_angle = angle_r;
    assign coil_a_target   = coil_a_r;
    assign coil_b_target   = coil_b_r;
    assign standstill_flag = standstill_r;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_sync_delay;
        step_act |-> ($past(step_pin, 2) != $past(step_pin, 3));
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("step edge used without two-stage sync");

    property p_single_edge;
        !dual_edge_select && step_prev_r && !step_s2_r |=> $stable(angle_r);
    endproperty
    a_single_edge: assert property (p_single_edge)
        else $error("falling edge stepped in single-edge mode");

    property p_dual_edge;
        dual_edge_select && !step_interface_disable && step_prev_r && !step_s2_r
            |-> step_act;
    endproperty
    a_dual_edge: assert property (p_dual_edge)
        else $error("falling edge ignored in dual-edge mode");

    property p_up_fine;
        step_act && !dir_s2_r && microstep_resolution == 4'h0
            |=> angle_r == $past(angle_r) + 10'h001;
    endproperty
    a_up_fine: assert property (p_up_fine)
        else $error("finest up step not plus one");

    property p_down_full;
        step_act && dir_s2_r && microstep_resolution == RES_COARSEST
            |=> angle_r == $past(angle_r) - 10'h100;
    endproperty
    a_down_full: assert property (p_down_full)
        else $error("full step down not minus 256");

    property p_wrap;
        step_act && !dir_s2_r && microstep_resolution == 4'h0 && angle_r == 10'h3ff
            |=> angle_r == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("angle did not wrap at 1024");

    property p_aligned;
        step_act && microstep_resolution == 4'h4
            |=> angle_r[3:0] == $past(angle_r[3:0]);
    endproperty
    a_aligned: assert property (p_aligned)
        else $error("sixteenth step disturbed low angle bits");

    // At ninety degrees the sine sits on the table peak and the cosine on the
    // negated first entry, since the table never stores a true zero.
    property p_peak;
        angle_r == ANGLE_QUARTER
            |=> coil_a_r == $signed({1'b0, TBL_PEAK}) && coil_b_r == -9'sd1;
    endproperty
    a_peak: assert property (p_peak)
        else $error("quarter angle does not give peak 248");

    property p_half_neg;
        angle_r[ANGLE_W-1 -: 2] == 2'b10 |=> coil_a_r < 0 && coil_b_r <= 0;
    endproperty
    a_half_neg: assert property (p_half_neg)
        else $error("third quadrant signs wrong");

    property p_bound;
        coil_a_r <= 9'sd248 && coil_a_r >= -9'sd248 && coil_b_r <= 9'sd248;
    endproperty
    a_bound: assert property (p_bound)
        else $error("coil target beyond table range");

    property p_still_set;
        !step_act && idle_cnt_r == IDLE_LAST |=> standstill_r;
    endproperty
    a_still_set: assert property (p_still_set)
        else $error("standstill not raised at idle limit");

    property p_still_clr;
        step_act |=> !standstill_r && idle_cnt_r == '0;
    endproperty
    a_still_clr: assert property (p_still_clr)
        else $error("active edge did not clear standstill");

    c_dual:  cover property (dual_edge_select && step_act && !step_s2_r);
    c_down:  cover property (step_act && dir_s2_r);
    c_still: cover property ($rose(standstill_r));

endmodule // sdms_sequencer

/* File: core/sdms_pkg.sv */
// Purpose: Shared constants and types of the step/dir microstep sequencer.
// Assumes: One system clock; widths fixed at the documented values.
// Notes:   Shared widths and constants are named here; the table width and read offset stay literals in sdms_quad_rom.

package sdms_pkg;

    // ==================================================================
    // Widths
    localparam int ANGLE_W        = 10;   // Microstep angle counter width.
    localparam int RES_W          = 4;    // Microstep resolution field width.
    localparam int COIL_W         = 9;    // Signed coil target width.
    localparam int TBL_IDX_W      = 8;    // Quarter-wave table index width.
    localparam int IDLE_CNT_W     = 21;   // Wide enough for the idle limit.

    // ==================================================================
    // Values
    localparam logic [RES_W-1:0]   RES_COARSEST  = 4'h8;    // Full step, 256 units.
    localparam logic [ANGLE_W-1:0] ANGLE_RST     = 10'h000; // Angle after reset.
    localparam logic [ANGLE_W-1:0] ANGLE_QUARTER = 10'h100; // Ninety degrees.
    localparam logic [7:0]         TBL_PEAK      = 8'hf8;   // Largest table value.

    // No active edge for this many system clocks raises the standstill flag.
    localparam int STANDSTILL_CYCLES_DFLT = 1 << 20;

    // ==================================================================
    // Quadrant selected by the two upper angle bits.
    typedef enum logic [1:0] {
        SDMS_Q0 = 2'b00,
        SDMS_Q1 = 2'b01,
        SDMS_Q2 = 2'b10,
        SDMS_Q3 = 2'b11
    } sdms_quad_t;

endpackage

/* File: core/sdms_quad_rom.sv */
// Purpose: Quarter-wave sine table and quadrant folding to sine and cosine.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Entry 0 sits in the top byte of the packed table constant.

`timescale 1ns/100ps

module sdms_quad_rom
    import sdms_pkg::*;
(
    input  wire logic        [ANGLE_W-1:0] angle,
    output logic signed      [COIL_W-1:0]  sine_val,
    output logic signed      [COIL_W-1:0]  cosine_val
);

    // ==================================================================
    // Quarter wave, rising from 1 to a peak of 248 so an offset still fits.
    localparam logic [2047:0] QTBL = {
        256'h0102040507080a0b0d0e101113151618191b1c1e1f2122242527282a2b2d2e30,
        256'h3133343637393a3c3d3e404143444647494a4c4d4f505153545657595a5b5d5e,
        256'h60616264656768696b6c6d6f707273747677787a7b7c7e7f8081838485878889,
        256'h8a8c8d8e8f91929394969798999a9c9d9e9fa0a1a3a4a5a6a7a8a9aaacadaeaf,
        256'hb0b1b2b3b4b5b6b7b8b9babbbcbdbebfc0c1c2c3c4c5c6c7c8c9c9cacbcccdce,
        256'hcfcfd0d1d2d3d4d4d5d6d7d7d8d9dadadbdcdcdddedfdfe0e1e1e2e2e3e4e4e5,
        256'he5e6e7e7e8e8e9e9eaeaebebececededeeeeeeefeff0f0f0f1f1f1f2f2f2f3f3,
        256'hf3f4f4f4f4f5f5f5f5f6f6f6f6f6f7f7f7f7f7f7f7f7f8f8f8f8f8f8f8f8f8f8
    };

    // Table read; a byte-wide part-select keeps the ROM a plain mux.
    function automatic logic [7:0] tbl(input logic [TBL_IDX_W-1:0] idx);
        tbl = QTBL[(11'h7ff - {idx, 3'h0}) -: 8];
    endfunction

    // Fold one stored quarter into a full signed period.
    function automatic logic signed [COIL_W-1:0] fold(input logic [ANGLE_W-1:0] a);
        logic [7:0] mag;
        mag = 8'h00;
        case (sdms_quad_t'(a[ANGLE_W-1 -: 2]))
            SDMS_Q0: begin
                mag  = tbl(a[TBL_IDX_W-1:0]);
                fold = $signed({1'b0, mag});
            end
            SDMS_Q1: begin
                mag  = tbl(~a[TBL_IDX_W-1:0]);
                fold = $signed({1'b0, mag});
            end
            SDMS_Q2: begin
                mag  = tbl(a[TBL_IDX_W-1:0]);
                fold = -$signed({1'b0, mag});
            end
            SDMS_Q3: begin
                mag  = tbl(~a[TBL_IDX_W-1:0]);
                fold = -$signed({1'b0, mag});
            end
            default: begin
                fold = '0;
            end
        endcase
    endfunction

    // Cosine is the sine shifted ahead by one quarter period.
    assign sine_val   = fold(angle);
    assign cosine_val = fold(angle + ANGLE_QUARTER);

endmodule // sdms_quad_rom

/* File: dv/sdms_step_ctrl.sv */
// Purpose: Motion controller model that issues step and direction levels.
// Assumes: Pins change only on the falling clock edge.
// Notes:   Each call toggles the step level once.

`timescale 1ns/100ps

module sdms_step_ctrl (
    input  wire logic clk,
    output logic      step_pin,
    output logic      dir_pin
);
    // ==========================================================
    // Pin driver
    // Both pins idle low so the first toggle is a rising edge.
    initial begin
        step_pin = 1'b0;
        dir_pin  = 1'b0;
    end

    // Direction settles two clocks ahead of the toggle. That also keeps each
    // step level at least three clocks long, which holds the step rate to at
    // most a third of the clock even when both edges count.
    task automatic toggle(input logic d);
        @(negedge clk);
        dir_pin = d;
        repeat (2) @(negedge clk);
        step_pin = ~step_pin;
    endtask
endmodule // sdms_step_ctrl

/* File: dv/sdms_tb.sv */
// Purpose: Self-checking bench for the microstep sequencer.
// Assumes: A short standstill count of 16 clocks keeps the run brief.
// Notes:   Expected angles are tracked here, never read back.

`timescale 1ns/100ps

module testbench;
    import sdms_pkg::*;

`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    err_count++; $display("wrong value %s exp %0d got %0d", n, e, a); end end

    localparam int SS = 16;
    logic                      clk, rst, dual, dis;
    logic [RES_W-1:0]          res;
    logic                      step_pin, dir_pin, flag;
    logic [ANGLE_W-1:0]        ang, ea;
    logic signed [COIL_W-1:0]  ca, cb;
    int                        err_count, cmp_count, cyc;
    // Targets at the eight half and full step positions.
    logic signed [COIL_W-1:0]  qa[8] = '{248, -1, -248, 1, 176, 175, -176, -175};
    logic signed [COIL_W-1:0]  qb[8] = '{-1, -248, 1, 248, 175, -176, -175, 176};

    // ==========================================================
    // Instances
    sdms_step_ctrl u_ctrl (.clk(clk), .step_pin(step_pin), .dir_pin(dir_pin));

    sdms_sequencer #(.STANDSTILL_CYCLES(SS)) u_dut (
        .clk(clk), .rst(rst), .step_pin(step_pin), .dir_pin(dir_pin),
        .dual_edge_select(dual), .microstep_resolution(res),
        .step_interface_disable(dis), .microstep_angle(ang),
        .coil_a_target(ca), .coil_b_target(cb), .standstill_flag(flag));

    // ==========================================================
    // Clock and hang guard
    // The ceiling is far above the few hundred clocks the tests need.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            close_out();
        end
    end

    // ==========================================================
    // Helpers
    // Four clocks cover the three-stage path to the angle plus the coils.
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask

    // One rising and one falling toggle, then check the angle.
    task automatic pulse(input logic d, input int inc, input string n);
        u_ctrl.toggle(d);
        settle();
        u_ctrl.toggle(d);
        settle();
        ea = ea + inc[ANGLE_W-1:0];
        `CHK(n, ea, ang)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        `CHK("angle", ANGLE_RST, ang)
        `CHK("coil_a", 9'sd1, ca)
        `CHK("coil_b", 9'sd248, cb)
    endtask

    // Full and half step positions walk all four quadrants.
    task automatic t_quad();
        for (int i = 0; i < 8; i++) begin
            res = (i == 4) ? 4'h7 : RES_COARSEST;
            pulse(1'b0, (i == 4) ? 128 : 256, "quad angle");
            `CHK("quad coil_a", qa[i], ca)
            `CHK("quad coil_b", qb[i], cb)
        end
    endtask

    // Nothing moves until the third clock after the pin changes.
    task automatic t_sync();
        res = 4'h0;
        u_ctrl.toggle(1'b0);
        repeat (2) @(negedge clk);
        `CHK("early angle", ea, ang)
        @(negedge clk);
        ea = ea + 10'h001;
        `CHK("angle", ea, ang)
        u_ctrl.toggle(1'b0);
        settle();
        `CHK("fall ignored", ea, ang)
    endtask

    task automatic t_dual();
        dual = 1'b1;
        pulse(1'b0, 2, "dual angle");
        dual = 1'b0;
    endtask

    // Fine steps down, then full steps; the walk from 899 ends one below zero.
    task automatic t_down();
        for (int i = 0; i < 4; i++) begin
            pulse(1'b1, -1, "down angle");
        end
        res = RES_COARSEST;
        for (int i = 0; i < 3; i++) begin
            pulse(1'b1, -256, "down full angle");
        end
        res = 4'h7;
        pulse(1'b1, -128, "wrap angle");
        `CHK("wrap value", 10'h3ff, ang)
    endtask

    // Codes above the coarsest one behave as full step.
    task automatic t_res();
        for (int r = 0; r < 10; r++) begin
            res = r[RES_W-1:0];
            pulse(1'b0, (r > 8) ? 256 : (1 << r), "res angle");
        end
    endtask

    task automatic t_dis();
        dis = 1'b1;
        pulse(1'b0, 0, "disabled angle");
        dis = 1'b0;
    endtask

    // The flag rises SS clocks after the edge that moved the angle. Only an
    // active edge clears it, so a falling edge in single-edge mode keeps it.
    task automatic t_idle();
        res = 4'h0;
        u_ctrl.toggle(1'b0);
        ea = ea + 10'h001;
        settle();
        `CHK("flag after edge", 1'b0, flag)
        repeat (SS - 2) @(negedge clk);
        `CHK("flag early", 1'b0, flag)
        @(negedge clk);
        `CHK("flag idle", 1'b1, flag)
        u_ctrl.toggle(1'b0);
        settle();
        `CHK("flag held", 1'b1, flag)
        pulse(1'b0, 1, "idle angle");
        `CHK("flag cleared", 1'b0, flag)
    endtask

    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        // Bring-up ends on an all-zero control word: finest steps, rising
        // edges only. Chopper, current and load-adaptive words reach no port.
        dual = 1'b0;
        dis = 1'b0;
        res = 4'h0;
        ea = ANGLE_RST;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_quad();
        t_sync();
        t_dual();
        t_down();
        t_res();
        t_dis();
        t_idle();
        close_out();
    end
endmodule // testbench
